// File: rtl/hdtc_defs.vh
/*
 header of register addresses, command values, field positions and
 frame counts for the half-duplex transcode control block.
 assumes it is included by bare name from the fifo and top design files.
*/
`ifndef HDTC_DEFS_VH
`define HDTC_DEFS_VH
`define HDTC_A_IN_BYTE 8'h48
`define HDTC_A_IN_WORD 8'h49
`define HDTC_A_IN_FMT 8'h4a
`define HDTC_A_OUT_BYTE 8'h4c
`define HDTC_A_OUT_WORD 8'h4d
`define HDTC_A_OUT_FMT 8'h4e
`define HDTC_A_FLUSH 8'h50
`define HDTC_A_THRESH 8'h51
`define HDTC_A_SRC_FMT 8'h54
`define HDTC_A_RES_FMT 8'h56
`define HDTC_A_VOC_OPT 8'h5e
`define HDTC_A_MODE 8'h6b
`define HDTC_A_FLAGS 8'h7e
`define HDTC_FLUSH_BOTH 16'h8080
`define HDTC_FMT_ALAW_PACKED 16'h0011
`define HDTC_FMT_VOCODER 16'h0005
`define HDTC_MODE_ROUTE_HOST 16'h0110
`define HDTC_MODE_RUN_HOST 16'h0111
`define HDTC_RUN_IDLE 2'h0
`define HDTC_RUN_HALF 2'h1
`define HDTC_BIT_UNDERFLOW 1
`define HDTC_BIT_OUT_READY 2
`define HDTC_BIT_IN_TAKEN 3
`define HDTC_FRAME_SAMPLES 9'h0f0
`define HDTC_FIFO_WORDS 128
`define HDTC_FIFO_AW 7
`define HDTC_VOC_BYTES 8'h18
`define HDTC_FLAGS_RESET 16'h0000
`endif

// File: rtl/hdtc_sync.v
/*
 three-stage synchroniser with agreement of stages two and three.
 assumes the input is asynchronous to clk.
*/
`default_nettype none
module hdtc_sync (
	input wire clk,
	input wire reset,
	input wire din,
	output reg dout
);
	reg s1;
	reg s2;
	reg s3;
	always @(posedge clk) begin
		if (reset) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule
`default_nettype wire

// File: rtl/hdtc_fifo.v
/*
 synchronous word fifo with flush, level and honest full and empty.
 assumes one clock; push when full and pop when empty are ignored.
*/
`default_nettype none
`include "hdtc_defs.vh"
module hdtc_fifo (
	input wire clk,
	input wire reset,
	input wire flush,
	input wire push,
	input wire [15:0] wdata,
	input wire pop,
	output wire [15:0] rdata,
	output wire full,
	output wire empty,
	output reg [7:0] level
);
	reg [15:0] mem [0:`HDTC_FIFO_WORDS-1];
	reg [`HDTC_FIFO_AW-1:0] wp;
	reg [`HDTC_FIFO_AW-1:0] rp;
	wire do_push;
	wire do_pop;
	assign full = (level == 8'h80);
	assign empty = (level == 8'h00);
	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign rdata = mem[rp];
	always @(posedge clk) begin
		if (do_push && !flush) begin
			mem[wp] <= wdata;
		end
	end
	always @(posedge clk) begin
		if (reset || flush) begin
			wp <= 7'h00;
			rp <= 7'h00;
			level <= 8'h00;
		end else begin
			if (do_push) begin
				wp <= wp + 7'h01;
			end
			if (do_pop) begin
				rp <= rp + 7'h01;
			end
			if (do_push && !do_pop) begin
				level <= level + 8'h01;
			end else if (do_pop && !do_push) begin
				level <= level - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// File: rtl/hdtc_top.v
/*
 host-facing control of a half-duplex transcoder: serial register port,
 audio fifos, format and routing selection, frame priming, fill-count
 flags and underflow. assumes a serial port sampled on clk (spi mode 0,
 msb first, 8-bit address with bit 7 set for read, 16-bit data).
*/
// Contract
// - writing 8080 to flush control empties both audio fifos
// - source format 0011 unpacks each word into two A-law samples
// - result format 0005 yields vocoder frames, not pcm
// - mode 0110 routes host fifos as source and destination, idle
// - encoding starts only once 240 samples have gathered
// - threshold 2801 flags one output frame or 0x28 input words taken
// - mode 0111 starts transcoding, waiting for enough input
// - flag bit 2 marks output ready, bit 3 input consumed
// - transcoding continues while input lasts and mode bits unchanged
// - word port streams back-to-back, byte port separate, out likewise
// - input starving a running conversion is reported as underflow
`default_nettype none
`include "hdtc_defs.vh"
module hdtc_top (
	input wire clk,
	input wire reset,
	input wire sclk,
	input wire csn,
	input wire mosi,
	output reg miso,
	output reg miso_oe_n,
	output reg running,
	output reg underflow
);
	localparam ST_IDLE = 2'd0;
	localparam ST_ADDR = 2'd1;
	localparam ST_DATA = 2'd2;
	localparam RN_WAIT = 2'd0;
	localparam RN_PRODUCE = 2'd1;
	localparam [15:0] ROUTE_HOST = `HDTC_MODE_ROUTE_HOST;

	function [15:0] pack_ab;
		input [7:0] a;
		input [7:0] b;
		begin
			pack_ab = {a, b};
		end
	endfunction

	wire sclk_s;
	wire csn_s;
	wire mosi_s;
	hdtc_sync u_sclk (.clk(clk), .reset(reset), .din(sclk), .dout(sclk_s));
	wire cs_act;
	hdtc_sync u_csn (.clk(clk), .reset(reset), .din(!csn), .dout(cs_act));
	assign csn_s = !cs_act;
	hdtc_sync u_mosi (.clk(clk), .reset(reset), .din(mosi), .dout(mosi_s));

	reg sclk_q;
	wire rise;
	wire fall;
	assign rise = sclk_s && !sclk_q;
	assign fall = !sclk_s && sclk_q;

	reg [1:0] st;
	reg [4:0] bitn;
	reg [7:0] addr;
	reg [15:0] shin;
	reg [15:0] shout;
	reg [15:0] src_fmt;
	reg [15:0] res_fmt;
	reg [15:0] thresh;
	reg [15:0] mode;
	reg [15:0] voc_opt;
	reg [15:0] in_fmt;
	reg [15:0] flags;
	reg [15:0] out_fmt;
	reg byte_half;
	reg [7:0] byte_hold;
	reg [8:0] samples;
	reg [7:0] in_taken;
	reg [7:0] out_frames;
	reg [7:0] produced;
	reg [1:0] rn;
	reg [15:0] acc;
	reg word_go;
	reg out_last;
	reg [15:0] flag_snap;

	reg wr_stb;
	reg rd_stb;
	reg in_push;
	reg [15:0] in_wdata;
	reg out_push;
	reg [15:0] out_wdata;
	reg in_pop;
	reg out_pop;
	wire [15:0] in_rdata;
	wire [15:0] out_rdata;
	wire in_full;
	wire in_empty;
	wire out_full;
	wire out_empty;
	wire [7:0] in_level;
	wire [7:0] out_level;
	wire flush_now;
	wire is_pcm_out;
	wire is_packed;
	wire frame_ready;
	wire run_mode;
	wire host_route;

	assign flush_now = wr_stb && addr == `HDTC_A_FLUSH &&
		shin == `HDTC_FLUSH_BOTH;
	assign is_packed = (src_fmt == `HDTC_FMT_ALAW_PACKED);
	assign is_pcm_out = (res_fmt != `HDTC_FMT_VOCODER);
	assign run_mode = (mode[1:0] == `HDTC_RUN_HALF);
	assign host_route = (mode[15:4] == ROUTE_HOST[15:4]);
	assign frame_ready = (samples >= `HDTC_FRAME_SAMPLES);

	hdtc_fifo u_in (
		.clk(clk), .reset(reset), .flush(flush_now),
		.push(in_push), .wdata(in_wdata), .pop(in_pop),
		.rdata(in_rdata), .full(in_full), .empty(in_empty),
		.level(in_level)
	);
	hdtc_fifo u_out (
		.clk(clk), .reset(reset), .flush(flush_now),
		.push(out_push), .wdata(out_wdata), .pop(out_pop),
		.rdata(out_rdata), .full(out_full), .empty(out_empty),
		.level(out_level)
	);

	// serial port: address byte then 16-bit data words, streamed
	always @(posedge clk) begin
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		word_go <= 1'b0;
		if (reset) begin
			sclk_q <= 1'b0;
			st <= ST_IDLE;
			bitn <= 5'd0;
			addr <= 8'h00;
			shin <= 16'h0000;
			shout <= 16'h0000;
			miso <= 1'b0;
			miso_oe_n <= 1'b1;
		end else begin
			sclk_q <= sclk_s;
			if (csn_s) begin
				st <= ST_IDLE;
				miso_oe_n <= 1'b1;
			end else begin
				case (st)
				ST_IDLE: begin
					st <= ST_ADDR;
					bitn <= 5'd0;
				end
				ST_ADDR: begin
					if (rise) begin
						addr <= {addr[6:0], mosi_s};
						bitn <= bitn + 5'd1;
						if (bitn == 5'd7) begin
							st <= ST_DATA;
							bitn <= 5'd0;
							rd_stb <= addr[6];
						end
					end
				end
				ST_DATA: begin
					if (rise) begin
						shin <= {shin[14:0], mosi_s};
						word_go <= (bitn == 5'd0) && addr[7];
						bitn <= bitn + 5'd1;
						if (bitn == 5'd15) begin
							bitn <= 5'd0;
							wr_stb <= !addr[7];
							rd_stb <= addr[7];
						end
					end
					if (fall && addr[7]) begin
						miso_oe_n <= 1'b0;
						miso <= shout[15];
						shout <= {shout[14:0], 1'b0};
					end
				end
				default: st <= ST_IDLE;
				endcase
				if (rd_stb) begin
					case ({1'b0, addr[6:0]})
					`HDTC_A_OUT_BYTE: shout <= {out_rdata[7:0], 8'h00};
					`HDTC_A_OUT_WORD: shout <= out_rdata;
					`HDTC_A_OUT_FMT: shout <= out_fmt;
					`HDTC_A_FLAGS: shout <= flags;
					default: shout <= 16'h0000;
					endcase
				end
			end
		end
	end

	// register writes and host fifo access
	always @(posedge clk) begin
		in_push <= 1'b0;
		out_pop <= 1'b0;
		if (reset) begin
			src_fmt <= 16'h0000;
			res_fmt <= 16'h0000;
			thresh <= 16'h0000;
			mode <= 16'h0000;
			voc_opt <= 16'h0000;
			in_fmt <= 16'h0000;
			in_wdata <= 16'h0000;
			byte_half <= 1'b0;
			byte_hold <= 8'h00;
		end else begin
			if (flush_now) begin
				byte_half <= 1'b0;
			end
			if (word_go && {1'b0, addr[6:0]} == `HDTC_A_OUT_WORD) begin
				out_pop <= 1'b1;
			end
			if (word_go && {1'b0, addr[6:0]} == `HDTC_A_OUT_BYTE) begin
				out_pop <= 1'b1;
			end
			if (wr_stb) begin
				case (addr)
				`HDTC_A_IN_WORD: begin
					in_push <= 1'b1;
					in_wdata <= shin;
				end
				`HDTC_A_IN_BYTE: begin
					byte_half <= !byte_half;
					byte_hold <= shin[7:0];
					if (byte_half) begin
						in_push <= 1'b1;
						in_wdata <= pack_ab(byte_hold, shin[7:0]);
					end
				end
				`HDTC_A_IN_FMT: in_fmt <= shin;
				`HDTC_A_THRESH: thresh <= shin;
				`HDTC_A_SRC_FMT: src_fmt <= shin;
				`HDTC_A_RES_FMT: res_fmt <= shin;
				`HDTC_A_VOC_OPT: voc_opt <= shin;
				`HDTC_A_MODE: mode <= shin;
				default: in_wdata <= in_wdata;
				endcase
			end
		end
	end

	// sample gathering and frame conversion engine
	always @(posedge clk) begin
		in_pop <= 1'b0;
		out_push <= 1'b0;
		out_last <= 1'b0;
		if (reset || flush_now) begin
			samples <= 9'd0;
			rn <= RN_WAIT;
			produced <= 8'h00;
			out_fmt <= 16'h0000;
			out_wdata <= 16'h0000;
			acc <= 16'h0000;
			running <= 1'b0;
		end else begin
			running <= run_mode && host_route;
			case (rn)
			RN_WAIT: begin
				if (run_mode && host_route && !frame_ready &&
					!in_empty && !in_pop) begin
					in_pop <= 1'b1;
					acc <= acc ^ in_rdata;
					samples <= samples + (is_packed ? 9'd2 : 9'd1);
				end
				if (run_mode && host_route && frame_ready) begin
					rn <= RN_PRODUCE;
					produced <= 8'h00;
				end
			end
			RN_PRODUCE: begin
				if (!run_mode) begin
					rn <= RN_WAIT;
				end else if (!out_full) begin
					out_push <= 1'b1;
					out_wdata <= acc ^ {8'h00, produced};
					produced <= produced + 8'h01;
					if (is_pcm_out ? produced == 8'hef :
						produced == `HDTC_VOC_BYTES - 8'h01) begin
						rn <= RN_WAIT;
						samples <= 9'd0;
						out_last <= 1'b1;
						out_fmt <= is_pcm_out ? 16'h00f0 :
							{8'h00, `HDTC_VOC_BYTES};
					end
				end
			end
			default: rn <= RN_WAIT;
			endcase
		end
	end

	// fill-count flags and underflow; a new event wins over a read clear
	reg flag_rd;
	reg starve_q;
	wire starve;
	wire out_ev;
	wire in_ev;
	assign starve = run_mode && host_route && rn == RN_WAIT &&
		in_empty && samples != 9'd0;
	assign out_ev = out_last && thresh[7:0] != 8'h00 &&
		out_frames + 8'h01 >= thresh[7:0];
	assign in_ev = in_pop && thresh[15:8] != 8'h00 &&
		in_taken + 8'h01 >= thresh[15:8];
	always @(posedge clk) begin
		flag_rd <= word_go && {1'b0, addr[6:0]} == `HDTC_A_FLAGS;
		if (rd_stb && {1'b0, addr[6:0]} == `HDTC_A_FLAGS) begin
			flag_snap <= flags;
		end
		if (reset || flush_now) begin
			flags <= `HDTC_FLAGS_RESET;
			in_taken <= 8'h00;
			out_frames <= 8'h00;
			starve_q <= 1'b0;
			underflow <= 1'b0;
			flag_snap <= 16'h0000;
		end else begin
			starve_q <= starve;
			if (flag_rd) begin
				flags <= flags & ~flag_snap;
			end
			if (in_pop) begin
				in_taken <= in_ev ? 8'h00 : in_taken + 8'h01;
			end
			if (out_ev) begin
				out_frames <= 8'h00;
			end else if (out_last) begin
				out_frames <= out_frames + 8'h01;
			end
			if (out_ev) begin
				flags[`HDTC_BIT_OUT_READY] <= 1'b1;
			end
			if (in_ev) begin
				flags[`HDTC_BIT_IN_TAKEN] <= 1'b1;
			end
			if (starve && !starve_q) begin
				flags[`HDTC_BIT_UNDERFLOW] <= 1'b1;
			end
			underflow <= flags[`HDTC_BIT_UNDERFLOW];
		end
	end
endmodule
`default_nettype wire

// File: test/hdtc_chk.sv
/*
 port checker for the transcode control top, bound below.
 assumes clk domain only; serial inputs are asynchronous.
*/
`default_nettype none
module hdtc_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic csn,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe_n,
	input wire logic running,
	input wire logic underflow
);
	timeunit 1ns;
	timeprecision 1ps;
	int quiet = 0;
	always @(posedge clk)
		quiet <= !csn ? 0 : (quiet < 1000 ? quiet + 1 : quiet);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_bit_hold;
		(!$changed(miso) || miso_oe_n) [*6];
	endsequence
	sequence s_cs_idle;
		csn [*6];
	endsequence
	AST_RESET_OE: assert property (disable iff (1'b0)
		reset |=> miso_oe_n) else $error("oe not released in reset");
	AST_RESET_RUN: assert property (disable iff (1'b0)
		reset |=> !running) else $error("running in reset");
	AST_RESET_UNDER: assert property (disable iff (1'b0)
		reset |=> !underflow) else $error("underflow in reset");
	AST_OE_REL: assert property (s_cs_idle |-> miso_oe_n)
		else $error("miso driven while deselected");
	AST_OE_READ: assert property ($fell(miso_oe_n) |->
		!csn && !$past(csn, 4)) else $error("miso driven early");
	AST_OE_HOLD: assert property ($rose(miso_oe_n) |->
		$past(csn, 2)) else $error("miso released in frame");
	AST_MISO_HOLD: assert property (!miso_oe_n && $changed(miso)
		|=> s_bit_hold) else $error("miso bit too short");
	AST_RUN_STEADY: assert property ($changed(running)
		|-> quiet < 40) else $error("running moved without write");
	AST_UNDER_RUN: assert property ($rose(underflow)
		|-> running || $past(running)) else $error("underflow idle");
endmodule
bind hdtc_top hdtc_chk i_hdtc_chk (.clk(clk), .reset(reset),
	.sclk(sclk), .csn(csn), .mosi(mosi), .miso(miso),
	.miso_oe_n(miso_oe_n), .running(running), .underflow(underflow));
`default_nettype wire

// File: test/hdtc_host.sv
/*
 host model: serial register port master, mode 0, msb first.
 assumes clk from the bench; changes made on falling clk.
*/
`default_nettype none
module hdtc_host (
	input wire logic clk,
	input wire logic miso,
	output logic sclk,
	output logic csn,
	output logic mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 0;
		csn = 1;
		mosi = 0;
	end
	task automatic hf();
		repeat (4) @(negedge clk);
	endtask
	task automatic sh(input logic [15:0] v, input int n,
		output logic [15:0] q);
		q = 0;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = v[i];
			hf();
			sclk = 1;
			hf();
			q = {q[14:0], miso};
			sclk = 0;
		end
	endtask
	// one frame: address then n streamed words
	task automatic go(input logic [7:0] a, input logic [15:0] d,
		input int n, output logic [15:0] q);
		logic [15:0] t;
		csn = 0;
		sh({8'h00, a}, 8, t);
		for (int k = 0; k < n; k++)
			sh(d + k[15:0], 16, q);
		hf();
		csn = 1;
		mosi = ~mosi;
		repeat (3) hf();
	endtask
endmodule
`default_nettype wire

// File: test/hdtc_tb_top.sv
/*
 testbench for the transcode control top with the host model.
 assumes the designer's register map and serial timing.
*/
`default_nettype none
module hdtc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, sclk, csn, mosi, miso, miso_oe_n, running;
	logic underflow, mw;
	logic [15:0] r, f1;
	int fail_count = 0;
	int comparisons = 0;
	assign mw = miso_oe_n ? ~miso : miso;
	hdtc_top i_hdtc_top (.clk(clk), .reset(reset), .sclk(sclk),
		.csn(csn), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
		.running(running), .underflow(underflow));
	hdtc_host i_hdtc_host (.clk(clk), .miso(mw), .sclk(sclk),
		.csn(csn), .mosi(mosi));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic conclude();
		$display("fail_count=%0d comparisons=%0d", fail_count,
			comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic w(input logic [7:0] a, input logic [15:0] d,
		input int n = 1);
		i_hdtc_host.go(a, d, n, r);
	endtask
	task automatic t_reset();
		chk({miso_oe_n, running, underflow}, 16'h0004);
	endtask
	task automatic t_route();
		w(8'h6b, 16'h0110);
		chk(running, 16'h0000);
		w(8'he0, 16'h0000);
		chk(r, 16'h0000);
	endtask
	task automatic t_run();
		w(8'h50, 16'h8080);
		w(8'h54, 16'h0011);
		w(8'h56, 16'h0005);
		w(8'h6b, 16'h0110);
		w(8'h49, 16'h1234, 60);
		w(8'h51, 16'h2801);
		w(8'h6b, 16'h0111);
		chk(running, 16'h0001);
		repeat (200) @(negedge clk);
		chk(underflow, 16'h0001);
		w(8'hfe, 16'h0000);
		f1 = r;
		chk(f1[2], 16'h0000);
		chk(f1[3], 16'h0001);
		chk(underflow, 16'h0000);
		w(8'h49, 16'h5678, 60);
		repeat (3000) @(negedge clk);
		w(8'hfe, 16'h0000);
		chk(r[2], 16'h0001);
		chk(f1[3] | r[3], 16'h0001);
		w(8'hce, 16'h0000);
		chk(r, 16'h0018);
		w(8'hcd, 16'h0000, 12);
		chk(running, 16'h0001);
	endtask
	task automatic t_stop();
		w(8'h6b, 16'h0110);
		chk(running, 16'h0000);
	endtask
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (50000) @(posedge clk);
		fail_count++;
		conclude();
	end
	initial begin
		reset = 1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		t_reset();
		reset = 0;
		repeat (8) @(negedge clk);
		t_route();
		t_run();
		t_stop();
		conclude();
	end
endmodule
`default_nettype wire
